// >>> urcg_rxcmd_gen.sv
// receive-command status byte generator with apb registers
// Functional notes
// - send a status byte whenever dp/dm single-ended line state changes
// - send a status byte whenever a vbus or id comparator changes
// - during packet receive, drive status byte whenever dir high and nxt low
// - at start-up, send status byte once dir low and stp low
// - on leaving low-power, serial or carkit mode, send once stp and dir low
// - during transmit, return status bytes only after link asserts stp
// - events during transmit wait until stp drops at transmit end
// - status byte content sampled when driven, not when triggered
// - bits 1:0 line state, bit0 dp receiver, bit1 dm receiver
// - bits 3:2 encode vbus level from the three comparators
// - bits 5:4 encode receive active, error and host disconnect
// - bit 6 equals id pin level
// - bit 7 set while any unmasked carkit latch bit is set
// - one undriven turnaround cycle at every dir change
// - status bytes only in synchronous mode, on link clock edges
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "urcg_defines.svh"
module urcg_rxcmd_gen
#(
  parameter int CK_W = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // ulpi pins, link clock sampled as data
  input wire logic ulpi_clk,
  input wire logic ulpi_stp,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  output urcg_pkg::urcg_byte_t ulpi_data_o,
  output logic ulpi_data_oe,
  // analogue receivers and comparators
  input wire logic dp_rx,
  input wire logic dm_rx,
  input wire logic session_end_comparator,
  input wire logic session_valid_comparator,
  input wire logic bus_power_valid_comparator,
  input wire logic id_pin,
  // receive, transmit and mode logic
  input wire logic sync_mode,
  input wire logic mode_exit,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic host_disconnect,
  input wire logic rx_byte_valid,
  input wire urcg_pkg::urcg_byte_t rx_data,
  input wire logic [CK_W-1:0] carkit_latch
);
  import urcg_pkg::*;

  // refuse latch widths the status byte cannot carry
  if (CK_W < 1 || CK_W > 8)
  begin : g_ck_w_bad
    $error("carkit latch width must be 1 to 8");
  end

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [`URCG_AS_W-1:0] as_s1, as_s2, as_s3, as_f, as_fd;
  wire [`URCG_AS_W-1:0] as_raw = {id_pin, bus_power_valid_comparator,
    session_valid_comparator, session_end_comparator, dm_rx, dp_rx, ulpi_stp, ulpi_clk};
  // a change counts once stages two and three agree
  wire [`URCG_AS_W-1:0] next_as_f = (as_s2 & as_s3) | (as_f & (as_s2 | as_s3));
  // cleared in reset so no unknown change event leaks into pending
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      as_s1 <= '0;
      as_s2 <= '0;
      as_s3 <= '0;
      as_f <= '0;
      as_fd <= '0;
    end
    else
    begin
      as_s1 <= as_raw;
      as_s2 <= as_s1;
      as_s3 <= as_s2;
      as_f <= next_as_f;
      as_fd <= as_f;
    end
  end
  wire ce = as_f[`URCG_AS_CLK] & ~as_fd[`URCG_AS_CLK];
  wire stp_s = as_f[`URCG_AS_STP];
  wire [1:0] ls_now = as_f[`URCG_AS_LS];
  wire [3:0] cmp_now = as_f[`URCG_AS_CMP];
  wire ls_chg = ls_now != as_fd[`URCG_AS_LS];
  wire cmp_chg = cmp_now != as_fd[`URCG_AS_CMP];

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  logic enable;
  logic [`URCG_EV_W-1:0] status, mask;
  logic [CK_W-1:0] ck_mask;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == `URCG_ADDR_CTRL;
  wire hit_stat = paddr == `URCG_ADDR_STATUS;
  wire hit_mask = paddr == `URCG_ADDR_MASK;
  wire hit_state = paddr == `URCG_ADDR_STATE;
  wire hit_ck = paddr == `URCG_ADDR_CKMASK;
  wire mapped = hit_ctrl | hit_stat | hit_mask | hit_state | hit_ck;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ---------------------------------------------
  // status byte assembly
  // ---------------------------------------------
  function automatic logic [1:0] vb_enc(input logic [2:0] c);
    // c = {vbus valid, session valid, session end}
    if (c[2])
      return `URCG_VB_VALID;
    else if (c[1])
      return `URCG_VB_SESS;
    else if (!c[0])
      return `URCG_VB_END;
    else
      return `URCG_VB_LOW;
  endfunction

  function automatic logic [1:0] rx_enc(input logic act, input logic err, input logic disc);
    if (disc)
      return `URCG_RX_DISC;
    else if (act)
      return err ? `URCG_RX_ERR : `URCG_RX_ACT;
    else
      return `URCG_RX_NONE;
  endfunction

  wire alt_int = |(carkit_latch & ck_mask);
  urcg_byte_t rxcmd_now;
  always_comb
  begin
    rxcmd_now[`URCG_B_LS] = ls_now;
    rxcmd_now[`URCG_B_VB] = vb_enc(cmp_now[2:0]);
    rxcmd_now[`URCG_B_RX] = rx_enc(rx_active, rx_error, host_disconnect);
    rxcmd_now[`URCG_B_ID] = cmp_now[3];
    rxcmd_now[`URCG_B_ALT] = alt_int;
  end

  // ---------------------------------------------
  // send scheduling
  // ---------------------------------------------
  urcg_state_t state, next_state;
  logic pending, pend_wake, stp_seen, alt_d;
  logic [7:0] last_cmd;
  // transmit hold-off until stp seen and released
  wire tx_block = tx_active & ~(stp_seen & ~stp_s);
  // wake sends wait for stp low with dir low
  wire wake_ok = pend_wake & ~stp_s;
  // only in synchronous mode, on link clock edges
  wire go = ce & sync_mode & enable & (rx_active | (pending & ~tx_block) | wake_ok);
  always_comb
  begin
    next_state = state;
    if (ce)
    begin
      unique case (state)
        URCG_IDLE: next_state = go ? URCG_TURN : URCG_IDLE;
        URCG_TURN: next_state = rx_active ? URCG_RX : URCG_CMD;
        URCG_CMD: next_state = rx_active ? URCG_RX : URCG_BACK;
        URCG_RX: next_state = rx_active ? URCG_RX : URCG_CMD;
        URCG_BACK: next_state = URCG_IDLE;
        default: next_state = URCG_IDLE;
      endcase
    end
  end
  // status byte on every receive cycle without a data byte
  wire rx_cmd = next_state == URCG_RX & ~rx_byte_valid;
  wire load_cmd = ce & (next_state == URCG_CMD | rx_cmd);
  wire next_dir = next_state != URCG_IDLE & next_state != URCG_BACK;
  // turnaround cycles leave the bus undriven
  wire next_oe = next_state == URCG_CMD | next_state == URCG_RX;
  wire [`URCG_EV_W-1:0] ev;
  assign ev[`URCG_EV_LS] = ls_chg;
  assign ev[`URCG_EV_CMP] = cmp_chg;
  assign ev[`URCG_EV_SENT] = load_cmd;
  assign ev[`URCG_EV_ALT] = alt_int & ~alt_d;
  wire rd_clr = rd & hit_stat;
  // set wins over the read clear
  wire [`URCG_EV_W-1:0] next_status = (status & {`URCG_EV_W{~rd_clr}}) | ev;
  assign irq = |(status & mask);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state <= URCG_IDLE;
      ulpi_dir <= 1'b0;
      ulpi_nxt <= 1'b0;
      ulpi_data_oe <= 1'b0;
      ulpi_data_o <= 8'h00;
      last_cmd <= 8'h00;
    end
    else if (ce)
    begin
      state <= next_state;
      ulpi_dir <= next_dir;
      ulpi_nxt <= next_state == URCG_RX & rx_byte_valid;
      ulpi_data_oe <= next_oe;
      ulpi_data_o <= load_cmd ? rxcmd_now : rx_data;
      if (load_cmd)
        last_cmd <= rxcmd_now;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pending <= 1'b0;
      pend_wake <= 1'b1;
      stp_seen <= 1'b0;
    end
    else
    begin
      // triggers merge into one pending send
      pending <= (pending & ~load_cmd) | ls_chg | cmp_chg;
      // mode exit rearms the wake send
      pend_wake <= (pend_wake & ~(load_cmd & ~stp_s)) | mode_exit;
      stp_seen <= tx_active & (stp_seen | stp_s);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      enable <= `URCG_CTRL_RST;
      status <= '0;
      mask <= `URCG_MASK_RST;
      ck_mask <= CK_W'(`URCG_CKMASK_RST);
      alt_d <= 1'b0;
    end
    else
    begin
      status <= next_status;
      alt_d <= alt_int;
      if (wr & hit_ctrl)
        enable <= pwdata[0];
      if (wr & hit_mask)
        mask <= pwdata[`URCG_EV_W-1:0];
      if (wr & hit_ck)
        ck_mask <= pwdata[CK_W-1:0];
    end
  end

  wire [31:0] rd_state = {20'h0000_0, ulpi_dir, pend_wake, tx_block, pending, last_cmd};
  assign prdata = !rd ? 32'h0000_0000 :
    hit_ctrl ? {31'h0000_0000, enable} :
    hit_stat ? {28'h000_0000, status} :
    hit_mask ? {28'h000_0000, mask} :
    hit_state ? rd_state :
    hit_ck ? 32'(ck_mask) : 32'h0000_0000;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_byte_content: assert property (load_cmd |=> ulpi_data_o == $past(rxcmd_now))
    else $error("status byte not sampled at drive time");
  a_field_pack: assert property (load_cmd |=> ulpi_data_o[1:0] == $past(ls_now)
    && ulpi_data_o[6] == $past(cmp_now[3]))
    else $error("line state or id field wrong");
  a_vbus_top: assert property (load_cmd && cmp_now[2] |=> ulpi_data_o[3:2] == 2'h3)
    else $error("vbus valid not encoded as three");
  a_rx_disc: assert property (load_cmd && host_disconnect |=> ulpi_data_o[5:4] == 2'h2)
    else $error("disconnect not encoded");
  a_alt_flag: assert property (load_cmd && alt_int |=> ulpi_data_o[7])
    else $error("alt interrupt bit missing");
  a_turn_undriven: assert property ($changed(ulpi_dir) |-> !ulpi_data_oe)
    else $error("bus driven in turnaround");
  a_rx_nxt_low: assert property (ulpi_dir && ulpi_data_oe && !ulpi_nxt
    |-> ulpi_data_o == last_cmd)
    else $error("receive cycle without status byte");
  a_tx_hold: assert property (state == URCG_IDLE && ce && tx_block && !rx_active
    && !wake_ok |=> state == URCG_IDLE)
    else $error("send during transmit hold-off");
  a_ls_sched: assert property (ls_chg |=> pending)
    else $error("line state change not scheduled");
  a_cmp_sched: assert property (cmp_chg |=> pending)
    else $error("comparator change not scheduled");
  a_clock_edge: assert property (!ce |=> $stable(ulpi_dir) && $stable(ulpi_data_o))
    else $error("ulpi output moved off link edge");
  a_wake_send: assert property (state == URCG_IDLE && go && !rx_active
    |=> ulpi_dir ##0 !ulpi_data_oe)
    else $error("wake send did not take the bus");
  c_cmd_send: cover property (state == URCG_CMD ##1 state == URCG_BACK);
  c_rx_cmd: cover property (state == URCG_RX && ulpi_data_oe && !ulpi_nxt);
  c_tx_release: cover property (tx_active && stp_seen && !stp_s && pending);
  c_irq: cover property ($rose(irq));
endmodule

// >>> urcg_defines.svh
// constants for the receive-command status byte generator
`ifndef URCG_DEFINES_SVH
`define URCG_DEFINES_SVH
// register byte addresses
`define URCG_ADDR_CTRL 8'h00
`define URCG_ADDR_STATUS 8'h04
`define URCG_ADDR_MASK 8'h08
`define URCG_ADDR_STATE 8'h0C
`define URCG_ADDR_CKMASK 8'h10
// reset values
`define URCG_CTRL_RST 1'h1
`define URCG_MASK_RST 4'h0
`define URCG_CKMASK_RST 8'h00
// event bit positions
`define URCG_EV_LS 0
`define URCG_EV_CMP 1
`define URCG_EV_SENT 2
`define URCG_EV_ALT 3
`define URCG_EV_W 4
// status byte field positions
`define URCG_B_LS 1:0
`define URCG_B_VB 3:2
`define URCG_B_RX 5:4
`define URCG_B_ID 6
`define URCG_B_ALT 7
// encodings
`define URCG_VB_LOW 2'h0
`define URCG_VB_END 2'h1
`define URCG_VB_SESS 2'h2
`define URCG_VB_VALID 2'h3
`define URCG_RX_NONE 2'h0
`define URCG_RX_ACT 2'h1
`define URCG_RX_ERR 2'h3
`define URCG_RX_DISC 2'h2
// async input vector layout: clk, stp, dp, dm, sess_end, sess_vld, vbus_vld, id
`define URCG_AS_W 8
`define URCG_AS_CLK 0
`define URCG_AS_STP 1
`define URCG_AS_LS 3:2
`define URCG_AS_CMP 7:4
`endif

// >>> urcg_pkg.sv
// types for the receive-command status byte generator
package urcg_pkg;
  typedef logic [7:0] urcg_byte_t;
  typedef enum logic [2:0] {
    URCG_IDLE = 3'b000,
    URCG_TURN = 3'b001,
    URCG_CMD = 3'b010,
    URCG_RX = 3'b011,
    URCG_BACK = 3'b100
  } urcg_state_t;
endpackage

// >>> urcg_link_model.sv
// link side model: link clock, stop pin, status byte capture
`timescale 1ns/1ns
module urcg_link_model
(
  // link pins
  output logic ulpi_clk,
  output logic ulpi_stp,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire urcg_pkg::urcg_byte_t ulpi_data_o,
  input wire logic ulpi_data_oe,
  // bench control
  input wire logic stp_req
);
  import urcg_pkg::*;
  urcg_byte_t cmds[$];
  urcg_byte_t rxq[$];
  int ta_err = 0;
  logic last_dir = 1'b0;
  // ----------------------------------------
  // clock, stop and bus watch
  // ----------------------------------------
  initial
  begin
    ulpi_clk = 1'b0;
    ulpi_stp = 1'b0;
    forever
    begin
      #62 ulpi_clk = 1'b1;
      ulpi_stp <= stp_req;
      #63 ulpi_clk = 1'b0;
    end
  end
  // bus left undriven at direction change
  always @(posedge ulpi_clk)
  begin
    if (ulpi_dir !== last_dir && ulpi_data_oe !== 1'b0)
      ta_err++;
    last_dir <= ulpi_dir;
  end
  // status byte when nxt low, packet byte when nxt high
  always @(posedge ulpi_clk)
    if (ulpi_dir === 1'b1 && ulpi_data_oe === 1'b1 && ulpi_nxt === 1'b0)
      cmds.push_back(ulpi_data_o);
    else if (ulpi_dir === 1'b1 && ulpi_data_oe === 1'b1 && ulpi_nxt === 1'b1)
      rxq.push_back(ulpi_data_o);
endmodule

// >>> urcg_rxcmd_gen_tb.sv
// self-checking bench for the status byte generator
`timescale 1ns/1ns
`include "urcg_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) fail_at(g, e); end
module urcg_rxcmd_gen_tb;
  import urcg_pkg::*;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, carkit_latch, ck_mask;
  logic [31:0] pwdata, prdata, rd, r;
  logic ulpi_clk, ulpi_stp, ulpi_dir, ulpi_nxt, ulpi_data_oe, stp_req;
  urcg_byte_t ulpi_data_o, rx_data, got;
  logic dp_rx, dm_rx, s_end, s_vld, v_vld, id_pin, sync_mode, mode_exit;
  logic tx_active, rx_active, rx_error, host_disc, rx_byte_valid;
  int miscompares, total_checks, i;
  urcg_rxcmd_gen dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ulpi_clk(ulpi_clk), .ulpi_stp(ulpi_stp),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_o(ulpi_data_o),
    .ulpi_data_oe(ulpi_data_oe), .dp_rx(dp_rx), .dm_rx(dm_rx),
    .session_end_comparator(s_end), .session_valid_comparator(s_vld),
    .bus_power_valid_comparator(v_vld), .id_pin(id_pin), .sync_mode(sync_mode),
    .mode_exit(mode_exit), .tx_active(tx_active), .rx_active(rx_active),
    .rx_error(rx_error), .host_disconnect(host_disc), .rx_byte_valid(rx_byte_valid),
    .rx_data(rx_data), .carkit_latch(carkit_latch));
  urcg_link_model link (.ulpi_clk(ulpi_clk), .ulpi_stp(ulpi_stp), .ulpi_dir(ulpi_dir),
    .ulpi_nxt(ulpi_nxt), .ulpi_data_o(ulpi_data_o), .ulpi_data_oe(ulpi_data_oe),
    .stp_req(stp_req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic urcg_byte_t expb();
    logic [1:0] vb;
    logic [1:0] rx;
    vb = v_vld ? 2'h3 : s_vld ? 2'h2 : s_end ? 2'h0 : 2'h1;
    rx = host_disc ? 2'h2 : rx_active ? {rx_error, 1'b1} : 2'h0;
    return {|(carkit_latch & ck_mask), id_pin, rx, vb, dm_rx, dp_rx};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail_at(input logic [31:0] g, input logic [31:0] e);
    miscompares++;
    $display("wrong value at %0t: got %h exp %h", $time, g, e);
  endtask
  task automatic hang();
    miscompares++;
    wrap_up();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic expect_cmd();
    int n;
    for (n = 0; n < 3000 && link.cmds.size() == 0; n++)
      @(posedge mclk);
    if (n == 3000)
      hang();
    got = link.cmds.pop_front();
    `CHK(got, expb())
  endtask
  task automatic flush();
    idle(400);
    link.cmds.delete();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, reset_n, stp_req, mode_exit} = '0;
    {dp_rx, dm_rx, s_vld, v_vld, id_pin, tx_active, rx_active, rx_error} = '0;
    {host_disc, rx_byte_valid, rx_data, ck_mask, miscompares, total_checks} = '0;
    s_end = 1'b1;
    sync_mode = 1'b1;
    carkit_latch = 8'h01;
    void'($urandom(32'h19e2aedd));
    idle(2);
    reset_n <= 1'b1;
    expect_cmd();
    flush();
    $display("start-up test done");
    for (i = 0; i < 8; i++)
    begin
      r = $urandom;
      s_end <= (i % 4 == 0) || (i % 4 > 1 && r[0]);
      s_vld <= (i % 4 == 2) || (i % 4 == 3 && r[1]);
      v_vld <= (i % 4 == 3);
      // first pass forces a line change so a send is always due
      dp_rx <= (i == 0) ? ~dp_rx : r[2];
      dm_rx <= r[3];
      id_pin <= r[4];
      @(posedge mclk);
      expect_cmd();
      idle(400);
      `CHK(link.cmds.size(), 0)
    end
    $display("change test done");
    apb(1'b1, `URCG_ADDR_MASK, 32'h0000_0004);
    `CHK(irq, 1'b1)
    apb(1'b0, `URCG_ADDR_STATE, 32'h0000_0000);
    `CHK(rd[7:0], expb())
    apb(1'b0, `URCG_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[2:1], 2'h3)
    apb(1'b0, `URCG_ADDR_STATUS, 32'h0000_0000);
    `CHK({rd[3:0], irq}, 5'h00)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, `URCG_ADDR_CKMASK, 32'h0000_0001);
    ck_mask = 8'h01;
    flush();
    dp_rx <= ~dp_rx;
    expect_cmd();
    apb(1'b0, `URCG_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[3], 1'b1)
    flush();
    $display("register test done");
    for (i = 0; i < 3; i++)
    begin
      rx_active <= 1'b1;
      rx_error <= (i == 1);
      host_disc <= (i == 2);
      flush();
      expect_cmd();
    end
    r = $urandom;
    rx_data <= r[7:0];
    rx_byte_valid <= 1'b1;
    flush();
    link.rxq.delete();
    idle(200);
    `CHK(link.cmds.size(), 0)
    `CHK(link.rxq.size() > 0, 1'b1)
    got = link.rxq.pop_front();
    `CHK(got, r[7:0])
    rx_byte_valid <= 1'b0;
    {rx_active, rx_error, host_disc} <= 3'h0;
    flush();
    $display("receive test done");
    tx_active <= 1'b1;
    idle(100);
    dp_rx <= ~dp_rx;
    idle(200);
    id_pin <= ~id_pin;
    idle(200);
    `CHK(link.cmds.size(), 0)
    stp_req <= 1'b1;
    idle(100);
    stp_req <= 1'b0;
    expect_cmd();
    tx_active <= 1'b0;
    idle(400);
    `CHK(link.cmds.size(), 0)
    $display("transmit test done");
    mode_exit <= 1'b1;
    @(posedge mclk);
    mode_exit <= 1'b0;
    expect_cmd();
    flush();
    sync_mode <= 1'b0;
    dm_rx <= ~dm_rx;
    idle(400);
    `CHK(link.cmds.size(), 0)
    sync_mode <= 1'b1;
    expect_cmd();
    idle(200);
    `CHK(link.ta_err, 0)
    $display("mode test done");
    wrap_up();
  end
endmodule
